// [pkg/vsic_regs.vh]
`ifndef VSIC_REGS_VH
`define VSIC_REGS_VH
// register offsets (8-bit address space)
`define VSIC_ADDR_CLKSEL     8'h03
`define VSIC_ADDR_HPOL       8'h12
`define VSIC_ADDR_VPOL       8'h14
`define VSIC_ADDR_CLAMPCTL   8'h18
`define VSIC_ADDR_CLAMPPOL   8'h1b
`define VSIC_ADDR_SLICESEL   8'h1d
`define VSIC_ADDR_SLEEPCTL   8'h1e
`define VSIC_ADDR_SLICETHR   8'h30
`define VSIC_ADDR_CLAMPDLY   8'h31
`define VSIC_ADDR_CLAMPDUR   8'h32
`define VSIC_ADDR_STATUS     8'h33
// field positions
`define VSIC_EXTCLK_BIT      2
`define VSIC_POL_HI          5
`define VSIC_POL_LO          4
`define VSIC_CLAMPEN_BIT     4
`define VSIC_COASTPOL_HI     7
`define VSIC_COASTPOL_LO     6
`define VSIC_CLAMPPOL_HI     7
`define VSIC_CLAMPPOL_LO     6
`define VSIC_SLEEPMAN_BIT    4
`define VSIC_SLEEPPOL_BIT    2
// polarity field: bit1=manual, bit0=level when manual
`define VSIC_POLF_MANUAL     1
// reset values
`define VSIC_RST_CLKSEL      8'h00
`define VSIC_RST_HPOL        8'h00
`define VSIC_RST_VPOL        8'h00
`define VSIC_RST_CLAMPCTL    8'hc0
`define VSIC_RST_CLAMPPOL    8'h00
`define VSIC_RST_SLICESEL    8'h00
`define VSIC_RST_SLEEPCTL    8'h04
`define VSIC_RST_SLICETHR    5'h0f
`define VSIC_RST_CLAMPDLY    8'h08
`define VSIC_RST_CLAMPDUR    8'h14
// threshold: code n means (n+1)*8 mV
`define VSIC_THR_STEP_MV     8
// slicer output sources
`define VSIC_SLC_RAWSOG      2'h0
`define VSIC_SLC_RAWLINE     2'h1
`define VSIC_SLC_REGEN       2'h2
`define VSIC_SLC_FILT        2'h3
`define VSIC_ACT_W           16
`endif

// [src/vsic_video_sync_input_control.v]
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "vsic_regs.vh"
// Summary of operation
// - polarity 0 falling edge, 1 rising edge
// - clock locks leading edge; clamp uses trailing
// - line sync polarity auto or forced
// - frame sync polarity auto or forced
// - frame sync drives field and coast
// - slicer threshold 8..256 mV, default 128
// - slicer gives noninverting sliced sync
// - external clamp only when enable bit set
// - otherwise clamp counted after trailing edge
// - clamp sense auto or forced
// - clock select bit picks external clock
// - coast freezes clock tracking
// - coast sense auto or forced, default 1
// - shared clock/coast pin functions independent
// - sleep pin manual select and polarity
// - three 10-bit colour words, bit 9 MSB
// - line sync out aligned with pixel clock
// - frame sync out and address pin independent
// - slicer output four selectable sources
// - address pin sampled once after reset
// - field output shows odd or even
module vsic_video_sync_input_control (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    input  wire [7:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [7:0]  regRdData,
    input  wire        chanSel,
    input  wire        line_sync_in_a,
    input  wire        line_sync_in_b,
    input  wire        frame_sync_in_a,
    input  wire        frame_sync_in_b,
    input  wire        embedded_sync_in_a,
    input  wire        embedded_sync_in_b,
    input  wire        sogCompA,
    input  wire        sogCompB,
    input  wire        clampPin,
    input  wire        external_sample_clock_in,
    input  wire        sleep_pin,
    input  wire        addr_lsb_select,
    input  wire [9:0]  redIn,
    input  wire [9:0]  greenIn,
    input  wire [9:0]  blueIn,
    output reg  [4:0]  sliceThreshold,
    output reg         slicer_out,
    output reg         clampActive,
    output reg         coastActive,
    output reg         pllTrackEdge,
    output reg         extClkSelect,
    output reg         sampleClkEdge,
    output reg         sleepActive,
    output reg         addrLsb,
    output reg  [9:0]  redOut,
    output reg  [9:0]  greenOut,
    output reg  [9:0]  blueOut,
    output reg         pixel_out_clock,
    output reg         line_sync_out,
    output reg         frame_sync_out,
    output reg         fieldOdd
);

    reg  [7:0] clkSelReg, hPolReg, vPolReg, clampCtlReg, clampPolReg;
    reg  [7:0] sliceSelReg, sleepCtlReg, clampDlyReg, clampDurReg;
    reg  [4:0] sliceThrReg;
    reg  [8:0] sync1Reg, sync2Reg;
    reg  [8:0] prevReg;
    reg  [`VSIC_ACT_W-1:0] hiCntReg [0:3];
    reg  [`VSIC_ACT_W-1:0] loCntReg [0:3];
    reg  [3:0] autoPolReg;
    reg  [7:0] clampCntReg;
    reg        clampPhaseReg;
    reg        clampRunReg;
    reg  [9:0] lineCntReg;
    reg        addrDoneReg;
    reg  [1:0] addrSyncReg;
    reg        lineHi, frameHi, sogHi, clampHi, coastHi;
    reg        hPol, vPol, cPol, kPol;
    integer    i;

    // resolve polarity: manual field wins, else measured level
    function sel_pol;
        input [1:0] field;
        input       autoVal;
        begin
            sel_pol = field[`VSIC_POLF_MANUAL] ? field[0] : autoVal;
        end
    endfunction

    // sync bits: 0 lineA 1 lineB 2 frameA 3 frameB 4 sogA 5 sogB
    // 6 clamp 7 shared clock/coast 8 sleep
    wire [8:0] rawIn = {sleep_pin, external_sample_clock_in, clampPin,
                        sogCompB, sogCompA, frame_sync_in_b,
                        frame_sync_in_a, line_sync_in_b, line_sync_in_a};
    wire [8:0] s = sync2Reg;

    always @* begin
        lineHi  = chanSel ? s[1] : s[0];
        frameHi = chanSel ? s[3] : s[2];
        sogHi   = chanSel ? s[5] : s[4];
        clampHi = s[6];
        coastHi = s[7];
        hPol = sel_pol(hPolReg[`VSIC_POL_HI:`VSIC_POL_LO], autoPolReg[0]);
        vPol = sel_pol(vPolReg[`VSIC_POL_HI:`VSIC_POL_LO], autoPolReg[1]);
        cPol = sel_pol(clampPolReg[`VSIC_CLAMPPOL_HI:`VSIC_CLAMPPOL_LO],
                       autoPolReg[2]);
        kPol = sel_pol(clampCtlReg[`VSIC_COASTPOL_HI:`VSIC_COASTPOL_LO],
                       autoPolReg[3]);
    end

    wire lineAct  = ~(lineHi ^ hPol);
    wire prevLine = chanSel ? prevReg[1] : prevReg[0];
    wire prevFrm  = chanSel ? prevReg[3] : prevReg[2];
    wire lineWas  = ~(prevLine ^ hPol);
    // active edge: falling when pol 0, rising when 1
    wire leadEdge  = lineAct & ~lineWas & (lineHi != prevLine);
    wire trailEdge = ~lineAct & lineWas & (lineHi != prevLine);
    wire frameAct  = ~(frameHi ^ vPol);
    wire frameLead = frameAct & (frameHi != prevFrm);
    // coast sense and clock edge read the pin independently
    wire coastNow  = ~(coastHi ^ kPol);
    wire extEdge   = s[7] & ~prevReg[7];
    wire [3:0] polSrc = {coastHi, clampHi, frameHi, lineHi};

    always @(posedge clk_sys) begin
        if (rst) begin
            sync1Reg <= 9'h000;
            sync2Reg <= 9'h000;
            prevReg  <= 9'h000;
        end else if (ce) begin
            sync1Reg <= rawIn;
            sync2Reg <= sync1Reg;
            prevReg  <= sync2Reg;
        end
    end

    // register write port
    always @(posedge clk_sys) begin
        if (rst) begin
            clkSelReg   <= `VSIC_RST_CLKSEL;
            hPolReg     <= `VSIC_RST_HPOL;
            vPolReg     <= `VSIC_RST_VPOL;
            // clamp enable resets to 0, coast pol 1
            clampCtlReg <= `VSIC_RST_CLAMPCTL;
            clampPolReg <= `VSIC_RST_CLAMPPOL;
            sliceSelReg <= `VSIC_RST_SLICESEL;
            sleepCtlReg <= `VSIC_RST_SLEEPCTL;
            sliceThrReg <= `VSIC_RST_SLICETHR;
            clampDlyReg <= `VSIC_RST_CLAMPDLY;
            clampDurReg <= `VSIC_RST_CLAMPDUR;
        end else if (ce && regWr) begin
            case (regAddr)
                `VSIC_ADDR_CLKSEL:   clkSelReg   <= regWrData;
                `VSIC_ADDR_HPOL:     hPolReg     <= regWrData;
                `VSIC_ADDR_VPOL:     vPolReg     <= regWrData;
                `VSIC_ADDR_CLAMPCTL: clampCtlReg <= regWrData;
                `VSIC_ADDR_CLAMPPOL: clampPolReg <= regWrData;
                `VSIC_ADDR_SLICESEL: sliceSelReg <= regWrData;
                `VSIC_ADDR_SLEEPCTL: sleepCtlReg <= regWrData;
                // code n gives (n+1) steps of 8 mV
                `VSIC_ADDR_SLICETHR: sliceThrReg <= regWrData[4:0];
                `VSIC_ADDR_CLAMPDLY: clampDlyReg <= regWrData;
                `VSIC_ADDR_CLAMPDUR: clampDurReg <= regWrData;
                default: ;
            endcase
        end
    end

    // read port, data valid the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (ce) begin
            regRdData <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    `VSIC_ADDR_CLKSEL:   regRdData <= clkSelReg;
                    `VSIC_ADDR_HPOL:     regRdData <= hPolReg;
                    `VSIC_ADDR_VPOL:     regRdData <= vPolReg;
                    `VSIC_ADDR_CLAMPCTL: regRdData <= clampCtlReg;
                    `VSIC_ADDR_CLAMPPOL: regRdData <= clampPolReg;
                    `VSIC_ADDR_SLICESEL: regRdData <= sliceSelReg;
                    `VSIC_ADDR_SLEEPCTL: regRdData <= sleepCtlReg;
                    `VSIC_ADDR_SLICETHR: regRdData <= {3'h0, sliceThrReg};
                    `VSIC_ADDR_CLAMPDLY: regRdData <= clampDlyReg;
                    `VSIC_ADDR_CLAMPDUR: regRdData <= clampDurReg;
                    `VSIC_ADDR_STATUS:
                        regRdData <= {1'b0, addrLsb, fieldOdd, coastActive,
                                      autoPolReg};
                    default:             regRdData <= 8'h00;
                endcase
            end
        end
    end

    // time high vs low per line; active level is the shorter
    always @(posedge clk_sys) begin
        if (rst) begin
            autoPolReg <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                hiCntReg[i] <= {`VSIC_ACT_W{1'b0}};
                loCntReg[i] <= {`VSIC_ACT_W{1'b0}};
            end
        end else if (ce) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (leadEdge) begin
                    autoPolReg[i] <= (hiCntReg[i] < loCntReg[i]);
                    hiCntReg[i] <= {`VSIC_ACT_W{1'b0}};
                    loCntReg[i] <= {`VSIC_ACT_W{1'b0}};
                end else if (polSrc[i]) begin
                    if (~&hiCntReg[i])
                        hiCntReg[i] <= hiCntReg[i] + 1'b1;
                end else if (~&loCntReg[i]) begin
                    loCntReg[i] <= loCntReg[i] + 1'b1;
                end
            end
        end
    end

    // internal clamp: delay then duration after trailing edge
    always @(posedge clk_sys) begin
        if (rst) begin
            clampCntReg   <= 8'h00;
            clampPhaseReg <= 1'b0;
            clampRunReg   <= 1'b0;
        end else if (ce) begin
            if (trailEdge) begin
                clampCntReg   <= clampDlyReg;
                clampPhaseReg <= 1'b0;
                clampRunReg   <= 1'b1;
            end else if (clampRunReg) begin
                if (clampCntReg != 8'h00) begin
                    clampCntReg <= clampCntReg - 8'h01;
                end else if (!clampPhaseReg) begin
                    clampCntReg   <= clampDurReg;
                    clampPhaseReg <= 1'b1;
                end else begin
                    clampRunReg <= 1'b0;
                end
            end
        end
    end

    wire intClamp = clampRunReg & clampPhaseReg;

    // address pin is asynchronous: two flops before the capture reads it
    always @(posedge clk_sys) begin
        if (ce)
            addrSyncReg <= {addrSyncReg[0], addr_lsb_select};
    end

    // address pin caught once after reset release
    always @(posedge clk_sys) begin
        if (rst) begin
            addrDoneReg <= 1'b0;
            addrLsb     <= 1'b0;
        end else if (ce && !addrDoneReg) begin
            addrDoneReg <= 1'b1;
            addrLsb     <= addrSyncReg[1];
        end
    end

    // outputs
    always @(posedge clk_sys) begin
        if (rst) begin
            sliceThreshold  <= 5'h0;
            slicer_out      <= 1'b0;
            clampActive     <= 1'b0;
            coastActive     <= 1'b0;
            pllTrackEdge    <= 1'b0;
            extClkSelect    <= 1'b0;
            sampleClkEdge   <= 1'b0;
            sleepActive     <= 1'b0;
            redOut          <= 10'h000;
            greenOut        <= 10'h000;
            blueOut         <= 10'h000;
            pixel_out_clock <= 1'b0;
            line_sync_out   <= 1'b0;
            frame_sync_out  <= 1'b0;
            fieldOdd        <= 1'b0;
            lineCntReg      <= 10'h000;
        end else if (ce) begin
            sliceThreshold <= sliceThrReg;
            case (sliceSelReg[1:0])
                `VSIC_SLC_RAWSOG:  slicer_out <= sogHi;
                `VSIC_SLC_RAWLINE: slicer_out <= lineHi;
                `VSIC_SLC_REGEN:   slicer_out <= lineAct;
                `VSIC_SLC_FILT:    slicer_out <= lineAct & lineWas;
                default:           slicer_out <= sogHi;
            endcase
            // external clamp gated by enable bit
            if (clampCtlReg[`VSIC_CLAMPEN_BIT])
                clampActive <= ~(clampHi ^ cPol);
            else
                clampActive <= intClamp;
            // coast also forced during frame sync
            coastActive  <= coastNow | frameAct;
            pllTrackEdge <= leadEdge & ~(coastNow | frameAct);
            extClkSelect  <= clkSelReg[`VSIC_EXTCLK_BIT];
            sampleClkEdge <= clkSelReg[`VSIC_EXTCLK_BIT] ? extEdge
                                                         : leadEdge;
            // manual sleep with programmable pin sense
            sleepActive <= sleepCtlReg[`VSIC_SLEEPMAN_BIT] &
                           ~(s[8] ^ sleepCtlReg[`VSIC_SLEEPPOL_BIT]);
            redOut   <= redIn;
            greenOut <= greenIn;
            blueOut  <= blueIn;
            pixel_out_clock <= ~pixel_out_clock;
            // line sync out updates with pixel clock rise
            if (!pixel_out_clock)
                line_sync_out <= lineAct;
            // frame output independent of address capture
            frame_sync_out <= frameAct;
            // odd line count between frames marks odd field
            if (frameLead) begin
                fieldOdd   <= lineCntReg[0];
                lineCntReg <= 10'h000;
            end else if (leadEdge) begin
                lineCntReg <= lineCntReg + 10'h001;
            end
        end
    end

endmodule

// [test/vsic_sync_props.sv]
`timescale 1ns/100ps
module vsic_sync_props (
    input wire       clk_sys,
    input wire       rst,
    input wire       ce,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWr,
    input wire [9:0] redIn,
    input wire [9:0] redOut,
    input wire [4:0] sliceThreshold,
    input wire       pllTrackEdge,
    input wire       coastActive,
    input wire       extClkSelect,
    input wire       addrLsb,
    input wire       pixel_out_clock,
    input wire       line_sync_out
);
    reg [4:0] thrShadow;
    reg       extShadow;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // shadows let the checks span the register-to-output latency
    always @(posedge clk_sys) begin
        if (ce && regWr && regAddr == 8'h30)
            thrShadow <= regWrData[4:0];
        if (ce && regWr && regAddr == 8'h03)
            extShadow <= regWrData[2];
    end
    pix_word_a: assert property (
        ce && !$past(rst) |=> redOut == $past(redIn))
        else $error("pixel word not passed on");
    line_align_a: assert property (
        $changed(line_sync_out) |-> $rose(pixel_out_clock))
        else $error("line sync moved off the pixel clock rise");
    pix_toggle_a: assert property (
        ce && !$past(rst) |=> pixel_out_clock != $past(pixel_out_clock))
        else $error("pixel clock did not toggle");
    ext_clk_sel_a: assert property (
        ce && regWr && regAddr == 8'h03 |-> ##2 extClkSelect == extShadow)
        else $error("clock select not following register");
    thr_write_a: assert property (
        ce && regWr && regAddr == 8'h30 |-> ##2 sliceThreshold == thrShadow)
        else $error("threshold code not following register");
    edge_pulse_a: assert property (
        pllTrackEdge |=> !pllTrackEdge)
        else $error("tracking pulse longer than one cycle");
    coast_block_a: assert property (
        coastActive && $past(coastActive) |-> !pllTrackEdge)
        else $error("tracking pulse during coast");
    addr_hold_a: assert property (
        !$past(rst) && !$past(rst, 2) |-> $stable(addrLsb))
        else $error("address bit changed after capture");
endmodule
bind vsic_video_sync_input_control vsic_sync_props u_props (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .redIn(redIn), .redOut(redOut),
    .sliceThreshold(sliceThreshold), .pllTrackEdge(pllTrackEdge),
    .coastActive(coastActive), .extClkSelect(extClkSelect),
    .addrLsb(addrLsb), .pixel_out_clock(pixel_out_clock),
    .line_sync_out(line_sync_out));

// [test/vsic_pixel_sink.sv]
`timescale 1ns/100ps
module vsic_pixel_sink (
    input  wire        clk_sys,
    input  wire        pixel_out_clock,
    input  wire        line_sync_out,
    output reg  [15:0] lineCount
);
    reg clkPrev = 1'b0;
    reg syncPrev = 1'b0;
    initial lineCount = 16'h0000;
    always @(posedge clk_sys) begin
        clkPrev <= pixel_out_clock;
        if (pixel_out_clock && !clkPrev) begin
            syncPrev <= line_sync_out;
            if (line_sync_out && !syncPrev)
                lineCount <= lineCount + 16'h0001;
        end
    end
endmodule

// [test/vsic_video_sync_input_control_tb.sv]
`timescale 1ns/100ps
module vsic_video_sync_input_control_tb;
    reg         clk_sys;
    reg         rst;
    reg         ce;
    reg  [7:0]  regAddr;
    reg  [7:0]  regWrData;
    reg         regWr;
    reg         regRd;
    reg         chanSel;
    reg         lineA;
    reg         frameA;
    reg         sogA;
    reg         clampPin;
    reg         extPin;
    reg         sleepPin;
    reg         addrSel;
    reg  [2:0]  rndIn;
    reg  [29:0] pixIn;
    reg  [31:0] seed;
    reg  [7:0]  thr;
    reg         rdSeen;
    reg  [7:0]  expQ[$];
    integer     mismatches;
    integer     comparisons;
    integer     i;
    integer     n;
    integer     hits;
    wire [7:0]  regRdData;
    wire [4:0]  sliceThreshold;
    wire [9:0]  redOut;
    wire [15:0] lineCount;
    wire        slicerOut, clampActive, coastActive, pllTrackEdge;
    wire        extClkSelect, sleepActive, addrLsb, pixClk, lineOut;
    wire        frameOut;
    logic [7:0] rstA[9] = '{8'h03, 8'h12, 8'h14, 8'h18, 8'h1b, 8'h1d,
                            8'h1e, 8'h30, 8'h55};
    logic [7:0] rstV[9] = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00,
                            8'h04, 8'h0f, 8'h00};
    vsic_video_sync_input_control u_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .chanSel(chanSel), .line_sync_in_a(lineA),
        .line_sync_in_b(rndIn[0]), .frame_sync_in_a(frameA),
        .frame_sync_in_b(rndIn[1]), .embedded_sync_in_a(1'b0),
        .embedded_sync_in_b(1'b0), .sogCompA(sogA), .sogCompB(rndIn[2]),
        .clampPin(clampPin), .external_sample_clock_in(extPin),
        .sleep_pin(sleepPin), .addr_lsb_select(addrSel),
        .redIn(pixIn[9:0]), .greenIn(pixIn[19:10]), .blueIn(pixIn[29:20]),
        .sliceThreshold(sliceThreshold), .slicer_out(slicerOut),
        .clampActive(clampActive), .coastActive(coastActive),
        .pllTrackEdge(pllTrackEdge), .extClkSelect(extClkSelect),
        .sampleClkEdge(), .sleepActive(sleepActive), .addrLsb(addrLsb),
        .redOut(redOut), .greenOut(), .blueOut(), .pixel_out_clock(pixClk),
        .line_sync_out(lineOut), .frame_sync_out(frameOut), .fieldOdd());
    vsic_pixel_sink u_sink (
        .clk_sys(clk_sys), .pixel_out_clock(pixClk),
        .line_sync_out(lineOut), .lineCount(lineCount));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [9:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // gap cycle after each strobe so no strobe is driven twice in a step
    // host paces its accesses, never faster than the port allows
    task automatic bus(input logic w, input logic [7:0] a, d);
        if (!w)
            expQ.push_back(d);
        regAddr <= a;
        regWrData <= d;
        regWr <= w;
        regRd <= !w;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic waitLine(input logic v);
        n = 0;
        while (lineA !== v) begin
            @(posedge clk_sys);
            n++;
            if (n == 40) begin
                mismatches++;
                wrap_up();
            end
        end
    endtask
    task automatic countHi(input integer k, input logic clamp);
        hits = 0;
        repeat (k) begin
            @(posedge clk_sys);
            hits += clamp ? clampActive : pllTrackEdge;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // line sync doubles as the unrelated link clock
    initial begin
        lineA = 1'b0;
        #3;
        forever #80 lineA = ~lineA;
    end
    always @(posedge clk_sys) begin
        seed = xs(seed);
        pixIn <= seed[29:0];
        rndIn <= {seed[31:30], seed[7]};
    end
    always @(posedge clk_sys) begin
        if (rdSeen)
            chk("read", {2'b00, regRdData}, expQ.pop_front());
        rdSeen <= regRd;
    end
    initial begin
        #600000;
        mismatches++;
        wrap_up();
    end
    initial begin
        {rst, ce, regWr, regRd, chanSel, frameA, sogA} = 7'h60;
        {clampPin, extPin, sleepPin, addrSel, rdSeen} = 5'h02;
        {regAddr, regWrData, rndIn, pixIn, mismatches, comparisons} = 0;
        seed = 32'h00003451;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (i = 0; i < 9; i++)
            bus(0, rstA[i], rstV[i]);
        bus(1, 8'h55, 8'hff);
        bus(0, 8'h55, 8'h00);
        chk("addr bit", addrLsb, 1);
        $display("reset contents done");
        foreach (rstV[i]) begin
            thr = (i == 0) ? 8'h00 : (i == 1) ? 8'h1f : {3'h0, seed[4:0]};
            bus(1, 8'h30, thr);
            bus(0, 8'h30, thr);
            chk("threshold", sliceThreshold, thr);
        end
        $display("threshold done");
        addrSel <= 1'b0;
        bus(1, 8'h14, 8'h30);
        bus(0, 8'h14, 8'h30);
        frameA <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("frame out", frameOut, 1);
        chk("addr bit kept", addrLsb, 1);
        frameA <= 1'b0;
        extPin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("coast", coastActive, 1);
        chk("clock sel", extClkSelect, 0);
        bus(1, 8'h03, 8'h04);
        repeat (2) @(posedge clk_sys);
        chk("clock sel", extClkSelect, 1);
        chk("coast kept", coastActive, 1);
        extPin <= 1'b0;
        bus(1, 8'h03, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("coast off", coastActive, 0);
        $display("coast and clock done");
        for (i = 0; i < 2; i++) begin
            bus(1, 8'h12, i ? 8'h30 : 8'h20);
            waitLine(!i[0]);
            waitLine(i[0]);
            countHi(8, 0);
            chk("leading edge", hits, 1);
            waitLine(!i[0]);
            countHi(8, 0);
            chk("trailing edge", hits, 0);
        end
        $display("sync edges done");
        bus(1, 8'h31, 8'h02);
        bus(1, 8'h32, 8'h02);
        bus(1, 8'h1b, 8'hc0);
        clampPin <= 1'b1;
        // let a trailing edge restart the clamp with the new timing
        repeat (20) @(posedge clk_sys);
        countHi(32, 1);
        chk("internal clamp", hits, 6);
        bus(1, 8'h18, 8'hd0);
        @(posedge clk_sys);
        countHi(32, 1);
        chk("pin clamp", hits, 32);
        clampPin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        countHi(16, 1);
        chk("pin clamp off", hits, 0);
        bus(1, 8'h18, 8'hc0);
        $display("clamp done");
        sogA <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("slicer sog", slicerOut, 1);
        bus(1, 8'h1d, 8'h01);
        waitLine(1'b0);
        waitLine(1'b1);
        repeat (4) @(posedge clk_sys);
        chk("slicer line", slicerOut, 1);
        for (i = 3; i >= 0; i--) begin
            bus(1, 8'h1d, i[7:0]);
            bus(0, 8'h1d, i[7:0]);
        end
        sogA <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("slicer sog low", slicerOut, 0);
        bus(1, 8'h1e, 8'h14);
        sleepPin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("sleep", sleepActive, 1);
        sleepPin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("sleep off", sleepActive, 0);
        chk("lines seen", lineCount != 0, 1);
        $display("slicer and sleep done");
        wrap_up();
    end
endmodule
